// ### core/pwd_pkg.sv
package pwd_pkg;

	// Register indices on the configuration write port.
	localparam logic [5:0] ADDR_HW_FIRST = 6'h00;
	localparam logic [5:0] ADDR_HW_LAST = 6'h0A;
	localparam logic [5:0] ADDR_GPIO_PULSE_CFG = 6'h09;
	localparam logic [5:0] ADDR_PARAM_LAST = 6'h13;
	localparam logic [5:0] ADDR_SOURCE_SEL = 6'h0D;
	localparam logic [5:0] ADDR_CH0_GAIN = 6'h0E;
	localparam logic [5:0] ADDR_CH0_BIAS = 6'h0F;
	localparam logic [5:0] ADDR_CH1_GAIN = 6'h10;
	localparam logic [5:0] ADDR_CH1_BIAS = 6'h11;

	// Field positions in the GPIO and pulse configuration register.
	localparam int DIR_LSB = 0;
	localparam int NUM_PORTS = 4;
	localparam int EN_LSB = 12;
	localparam int CH1_CARRIER_LSB = 14;
	localparam int CH0_CARRIER_LSB = 16;
	localparam int CH1_RES_LSB = 18;
	localparam int CH0_RES_LSB = 20;
	localparam int CH0_DENSITY_BIT = 22;
	localparam int CH1_DENSITY_BIT = 23;

	// Field positions in the source select register.
	localparam int CH0_SRC_LSB = 0;
	localparam int CH1_SRC_LSB = 4;
	localparam int SRC_W = 3;
	localparam int NUM_SRC = 8;

	// Values after reset: all ports inputs, parameters cleared.
	localparam logic [23:0] GPIO_CFG_RESET = 24'h00000F;
	localparam logic [23:0] PARAM_RESET = 24'h000000;
	localparam logic [23:0] RD_DATA_RESET = 24'h000000;

	// Mapping: output = gain * result / 2^GAIN_FRAC + bias.
	localparam int GAIN_FRAC = 16;
	localparam int RES_W = 24;
	localparam int VAL_W = 10;
	localparam logic [3:0] RES_BASE_BITS = 4'h7;

	// Carrier rates in kHz and the core clock rate they are drawn from.
	localparam int CLK_KHZ = 50000;
	localparam int CARRIER_FAST_KHZ = 8000;
	localparam int CARRIER_MID_KHZ = 1000;
	localparam int CARRIER_SLOW_KHZ = 100;
	localparam int PHASE_W = 16;
	localparam int MIN_TICK_GAP = CLK_KHZ / CARRIER_FAST_KHZ;

	typedef enum logic [1:0] {
		PWD_CAR_FAST = 2'b00,
		PWD_CAR_MID = 2'b01,
		PWD_CAR_SLOW = 2'b10,
		PWD_CAR_SLOW2 = 2'b11
	} pwd_carrier_t;

endpackage : pwd_pkg

// ### core/pwd_chan.sv
`timescale 1ns/1ps
`default_nettype none
module pwd_chan (
	// Clock, reset and enable.
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Carrier and setup.
	input wire logic carrier_tick,
	input wire logic density_mode,
	input wire logic [3:0] res_bits,
	input wire logic [9:0] value,
	// Stream.
	output logic pulse_q
);
	logic [9:0] cnt_q;
	logic [9:0] cnt_d;
	logic [9:0] cur_q;
	logic [10:0] acc_q;
	logic [10:0] acc_d;
	logic pulse_d;
	wire [10:0] full = 11'h001 << res_bits;
	wire [9:0] top = 10'((full - 11'h001));
	wire period_end = (cnt_q == top);
	wire [10:0] acc_sum = acc_q + {1'b0, cur_q};
	wire acc_carry = (acc_sum >= full);

	// Width mode: high for the first cur_q ticks of each period. [RL16]
	// Density mode: first-order accumulator spreads the same count. [RL16]
	assign cnt_d = period_end ? 10'h000 : 10'(cnt_q + 10'h001);
	assign acc_d = acc_carry ? 11'(acc_sum - full) : acc_sum;
	assign pulse_d = density_mode ? acc_carry : (cnt_q < cur_q);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 10'h000;
			cur_q <= 10'h000;
			acc_q <= 11'h000;
			pulse_q <= 1'b0;
		end else if (clk_en && carrier_tick) begin
			cnt_q <= cnt_d;
			acc_q <= density_mode ? acc_d : 11'h000;
			pulse_q <= pulse_d;
			if (period_end) begin
				cur_q <= value;
			end
		end
	end

	property p_zero_low;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(pulse_q) |-> $past(cur_q) != 10'h000;
	endproperty
	a_zero_low: assert property (p_zero_low) else $error("pulse with zero value"); // [RL12]

	property p_full_high;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && carrier_tick && !density_mode && cur_q == top
			&& cnt_q != top) |=> pulse_q;
	endproperty
	a_full_high: assert property (p_full_high) else $error("max value not high"); // [RL12]

endmodule : pwd_chan
`default_nettype wire

// ### core/pwd_top.sv
// Operation
// RL1: Two pulse channels each produce a width or density modulated stream from measurement results.
// RL2: Each channel takes any one measurement result, chosen by its source select field.
// RL3: A pulse drives a general-purpose port only while that port's direction bit makes it an output.
// RL4: Ports zero and one serve the serial interface until the OTP pin is low and the two-wire pin high.
// RL5: Each channel runs on an 8 MHz, 1 MHz or 100 kHz carrier picked by its carrier select field.
// RL6: Software is advised to pick the 100 kHz low-frequency carrier.
// RL7: Each channel's resolution comes from its resolution field.
// RL8: The 24-bit result is converted to an output value of at most 10 bits.
// RL9: The conversion is a linear function with signed per-channel gain and bias.
// RL10: The mapped value is limited to zero up to 2^N-1, 1023 at ten bits.
// RL11: Mapped values outside the valid range are ignored and leave the stream unchanged.
// RL12: The minimum value gives zero modulation and the maximum value all ones; the code keeps 2^N-1 high for 2^N-1 of every 2^N periods.
// RL13: Configuration registers are write-only and read back as zero.
// RL14: Hardware settings live at addresses 0 to 10 and parameters at 11 to 19.
// RL15: Source select sits at 13, channel zero gain and bias at 14 and 15, channel one at 16 and 17.
// RL16: A value v at resolution N is high for v of every 2^N carrier periods.
`timescale 1ns/1ps
`default_nettype none
module pwd_top (
	// Clock, reset, enable.
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Configuration write and read port.
	input wire logic cfg_wr_en,
	input wire logic [5:0] cfg_wr_addr,
	input wire logic [23:0] cfg_wr_data,
	input wire logic cfg_rd_en,
	input wire logic [5:0] cfg_rd_addr,
	output logic [23:0] cfg_rd_data_q,
	output logic cfg_rd_valid_q,
	// Measurement results.
	input wire logic meas_valid,
	input wire logic [pwd_pkg::NUM_SRC-1:0][23:0] meas_results,
	// Mode pins.
	input wire logic vpp_otp_pin,
	input wire logic two_wire_enable_pin,
	// General-purpose ports.
	output logic [pwd_pkg::NUM_PORTS-1:0] gp_out_q,
	output logic [pwd_pkg::NUM_PORTS-1:0] gp_oe_q
);
	logic [23:0] gpio_cfg_q;
	logic [23:0] src_sel_q;
	logic [1:0][23:0] gain_q;
	logic [1:0][23:0] bias_q;
	logic [1:0][9:0] ch_val_q;
	logic [1:0][9:0] ch_val_d;
	logic [1:0] ch_load;
	logic [1:0][pwd_pkg::PHASE_W-1:0] phase_q;
	logic [1:0][pwd_pkg::PHASE_W-1:0] phase_d;
	logic [1:0] tick_q;
	logic [1:0] tick_d;
	logic [1:0] ch_pulse;
	logic [1:0] vpp_meta_q;
	logic [1:0] twe_meta_q;
	logic vpp_sync_q;
	logic twe_sync_q;
	logic spi_free_q;
	logic [pwd_pkg::NUM_PORTS-1:0] gp_out_d;
	logic [pwd_pkg::NUM_PORTS-1:0] gp_oe_d;

	function automatic logic signed [50:0] map_value(
		input logic [23:0] result,
		input logic [23:0] gain,
		input logic [23:0] bias
	);
		logic signed [49:0] prod;
		prod = $signed({1'b0, result}) * $signed({{1{gain[23]}}, gain});
		map_value = 51'(prod >>> pwd_pkg::GAIN_FRAC) + 51'($signed(bias));
	endfunction : map_value

	function automatic logic [3:0] res_of(input logic [1:0] field);
		res_of = 4'(pwd_pkg::RES_BASE_BITS + {2'b00, field});
	endfunction : res_of

	function automatic logic [pwd_pkg::PHASE_W-1:0] carrier_inc(
		input logic [1:0] sel
	);
		case (sel)
			pwd_pkg::PWD_CAR_FAST: carrier_inc = 16'(pwd_pkg::CARRIER_FAST_KHZ);
			pwd_pkg::PWD_CAR_MID: carrier_inc = 16'(pwd_pkg::CARRIER_MID_KHZ);
			default: carrier_inc = 16'(pwd_pkg::CARRIER_SLOW_KHZ);
		endcase
	endfunction : carrier_inc

	// Register decode.
	wire wr_gpio = cfg_wr_en && (cfg_wr_addr == pwd_pkg::ADDR_GPIO_PULSE_CFG);
	wire wr_src = cfg_wr_en && (cfg_wr_addr == pwd_pkg::ADDR_SOURCE_SEL);
	wire [1:0] wr_gain;
	wire [1:0] wr_bias;
	assign wr_gain[0] = cfg_wr_en && (cfg_wr_addr == pwd_pkg::ADDR_CH0_GAIN);
	assign wr_bias[0] = cfg_wr_en && (cfg_wr_addr == pwd_pkg::ADDR_CH0_BIAS);
	assign wr_gain[1] = cfg_wr_en && (cfg_wr_addr == pwd_pkg::ADDR_CH1_GAIN);
	assign wr_bias[1] = cfg_wr_en && (cfg_wr_addr == pwd_pkg::ADDR_CH1_BIAS);

	// Configuration fields.
	wire [3:0] dir_in = gpio_cfg_q[pwd_pkg::DIR_LSB +: pwd_pkg::NUM_PORTS];
	wire [1:0] pulse_out_enable = gpio_cfg_q[pwd_pkg::EN_LSB +: 2];
	wire [1:0] ch0_carrier_sel = gpio_cfg_q[pwd_pkg::CH0_CARRIER_LSB +: 2];
	wire [1:0] ch1_carrier_sel = gpio_cfg_q[pwd_pkg::CH1_CARRIER_LSB +: 2];
	wire [1:0] ch0_resolution = gpio_cfg_q[pwd_pkg::CH0_RES_LSB +: 2];
	wire [1:0] ch1_resolution = gpio_cfg_q[pwd_pkg::CH1_RES_LSB +: 2];
	wire [1:0] ch_density;
	assign ch_density[0] = gpio_cfg_q[pwd_pkg::CH0_DENSITY_BIT];
	assign ch_density[1] = gpio_cfg_q[pwd_pkg::CH1_DENSITY_BIT];
	wire [2:0] ch0_source_sel = src_sel_q[pwd_pkg::CH0_SRC_LSB +: pwd_pkg::SRC_W];
	wire [2:0] ch1_source_sel = src_sel_q[pwd_pkg::CH1_SRC_LSB +: pwd_pkg::SRC_W];
	wire [1:0][3:0] ch_res;
	wire [1:0][1:0] ch_carrier;
	wire [1:0][23:0] ch_src;
	assign ch_res[0] = res_of(ch0_resolution); // [RL7]
	assign ch_res[1] = res_of(ch1_resolution); // [RL7]
	assign ch_carrier[0] = ch0_carrier_sel;
	assign ch_carrier[1] = ch1_carrier_sel;
	assign ch_src[0] = meas_results[ch0_source_sel]; // [RL2]
	assign ch_src[1] = meas_results[ch1_source_sel]; // [RL2]

	// Mapping, range check and carrier phase per channel.
	wire [1:0][50:0] ch_map;
	wire [1:0][50:0] ch_max;
	genvar c;
	for (c = 0; c < 2; c++) begin : g_ch
		wire [16:0] phase_sum = {1'b0, phase_q[c]} + {1'b0, carrier_inc(ch_carrier[c])};
		assign ch_map[c] = map_value(ch_src[c], gain_q[c], bias_q[c]); // [RL8] [RL9]
		assign ch_max[c] = (51'h1 << ch_res[c]) - 51'h1; // [RL10]
		assign ch_load[c] = meas_valid && !ch_map[c][50]
			&& (ch_map[c] <= ch_max[c]); // [RL11]
		assign ch_val_d[c] = ch_load[c] ? ch_map[c][9:0] : ch_val_q[c];
		// Fractional divider gives the exact average carrier rate.
		assign tick_d[c] = (phase_sum >= 17'(pwd_pkg::CLK_KHZ)); // [RL5]
		assign phase_d[c] = tick_d[c] ? 16'(phase_sum - 17'(pwd_pkg::CLK_KHZ))
			: phase_sum[15:0];

		pwd_chan u_chan (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.clk_en(clk_en),
			.carrier_tick(tick_q[c]),
			.density_mode(ch_density[c]),
			.res_bits(ch_res[c]),
			.value(ch_val_q[c]),
			.pulse_q(ch_pulse[c])
		); // [RL1]
	end

	// Port routing: channel 0 to ports 0 and 2, channel 1 to ports 1 and 3.
	wire [3:0] port_ok;
	assign port_ok[0] = spi_free_q; // [RL4]
	assign port_ok[1] = spi_free_q; // [RL4]
	assign port_ok[2] = 1'b1;
	assign port_ok[3] = 1'b1;
	for (c = 0; c < pwd_pkg::NUM_PORTS; c++) begin : g_port
		assign gp_oe_d[c] = pulse_out_enable[c % 2] && !dir_in[c] && port_ok[c]; // [RL3]
		assign gp_out_d[c] = gp_oe_d[c] && ch_pulse[c % 2];
	end
	wire rd_in_map = (cfg_rd_addr <= pwd_pkg::ADDR_PARAM_LAST); // [RL14]

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vpp_meta_q <= 2'b00;
			twe_meta_q <= 2'b00;
			vpp_sync_q <= 1'b0;
			twe_sync_q <= 1'b0;
			spi_free_q <= 1'b0;
		end else if (clk_en) begin
			vpp_meta_q <= {vpp_meta_q[0], vpp_otp_pin};
			twe_meta_q <= {twe_meta_q[0], two_wire_enable_pin};
			vpp_sync_q <= vpp_meta_q[1];
			twe_sync_q <= twe_meta_q[1];
			spi_free_q <= !vpp_sync_q && twe_sync_q; // [RL4]
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_cfg_q <= pwd_pkg::GPIO_CFG_RESET;
			src_sel_q <= pwd_pkg::PARAM_RESET;
			gain_q <= {2{pwd_pkg::PARAM_RESET}};
			bias_q <= {2{pwd_pkg::PARAM_RESET}};
		end else if (clk_en) begin
			if (wr_gpio) gpio_cfg_q <= cfg_wr_data;
			if (wr_src) src_sel_q <= cfg_wr_data; // [RL15]
			for (int i = 0; i < 2; i++) begin
				if (wr_gain[i]) gain_q[i] <= cfg_wr_data; // [RL15]
				if (wr_bias[i]) bias_q[i] <= cfg_wr_data; // [RL15]
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ch_val_q <= '0;
			phase_q <= '0;
			tick_q <= 2'b00;
			gp_out_q <= '0;
			gp_oe_q <= '0;
			cfg_rd_data_q <= pwd_pkg::RD_DATA_RESET;
			cfg_rd_valid_q <= 1'b0;
		end else if (clk_en) begin
			ch_val_q <= ch_val_d;
			phase_q <= phase_d;
			tick_q <= tick_d;
			gp_out_q <= gp_out_d;
			gp_oe_q <= gp_oe_d;
			cfg_rd_data_q <= pwd_pkg::RD_DATA_RESET; // [RL13]
			cfg_rd_valid_q <= cfg_rd_en && rd_in_map;
		end
	end

	property p_rd_zero;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && cfg_rd_en) |=> (cfg_rd_data_q == 24'h000000);
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("config read not zero"); // [RL13]

	property p_dir_out;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && dir_in[2]) |=> !gp_oe_q[2];
	endproperty
	a_dir_out: assert property (p_dir_out) else $error("input port driven"); // [RL3]

	property p_spi_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && !spi_free_q) |=> (gp_oe_q[1:0] == 2'b00);
	endproperty
	a_spi_hold: assert property (p_spi_hold) else $error("spi port driven"); // [RL4]

	property p_range;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && ch_load[0]) |=> ({41'h0, ch_val_q[0]} <= $past(ch_max[0]));
	endproperty
	a_range: assert property (p_range) else $error("value above max"); // [RL10]

	property p_ignore;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && meas_valid && ch_map[1] > ch_max[1]) |=> $stable(ch_val_q[1]);
	endproperty
	a_ignore: assert property (p_ignore) else $error("out of range taken"); // [RL11]

	property p_load;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && ch_load[0]) |=> (ch_val_q[0] == $past(ch_map[0][9:0]));
	endproperty
	a_load: assert property (p_load) else $error("mapped value lost"); // [RL9]

	property p_src_write;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && cfg_wr_en && cfg_wr_addr == 6'h0D)
			|=> (ch1_source_sel == $past(cfg_wr_data[6:4]));
	endproperty
	a_src_write: assert property (p_src_write) else $error("source not set"); // [RL15]

	property p_tick_gap;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(tick_q[0]) && clk_en |=> !tick_q[0] [*5];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("carrier too fast"); // [RL5]

	property p_port_follow;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && gp_oe_d[2]) |=> (gp_out_q[2] == $past(ch_pulse[0]));
	endproperty
	a_port_follow: assert property (p_port_follow) else $error("port lost pulse"); // [RL1]

	c_load: cover property (@(posedge core_clk) disable iff (!rst_n) ch_load[1]);
	c_pulse_p0: cover property (@(posedge core_clk) disable iff (!rst_n)
		gp_oe_q[0] && gp_out_q[0]);
	c_density: cover property (@(posedge core_clk) disable iff (!rst_n)
		ch_density[0] && $rose(ch_pulse[0]));

endmodule : pwd_top
`default_nettype wire

// ### testbench/pwd_filter_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwd_filter_model (
	// Clock.
	input wire logic core_clk,
	// Port pin.
	input wire logic pin_out,
	input wire logic pin_oe,
	// Measurement window.
	input wire logic start,
	input wire logic [15:0] win,
	// Results.
	output logic [15:0] high_cnt,
	output logic [15:0] rise_cnt
);
	logic [15:0] left_q;
	logic prev_q;
	wire logic level;
	// The filter resistor pulls an undriven port down to ground.
	assign level = pin_oe ? pin_out : 1'b0;
	initial begin
		left_q = 16'h0000;
		prev_q = 1'b0;
		high_cnt = 16'h0000;
		rise_cnt = 16'h0000;
	end
	// The capacitor charge over one window tracks the high time.
	always @(posedge core_clk) begin
		prev_q <= level;
		if (start) begin
			left_q <= win;
			high_cnt <= 16'h0000;
			rise_cnt <= 16'h0000;
		end else if (left_q != 16'h0000) begin
			left_q <= left_q - 16'h0001;
			high_cnt <= high_cnt + 16'(level);
			rise_cnt <= rise_cnt + 16'(level & ~prev_q);
		end
	end
endmodule : pwd_filter_model
`default_nettype wire

// ### testbench/pwd_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin \
	$display("wrong value at %0t: %s", $time, m); n_fail++; end end
module testbench;
	logic core_clk, rst_n, clk_en, cfg_wr_en, cfg_rd_en, meas_valid;
	logic [5:0] cfg_wr_addr, cfg_rd_addr;
	logic [23:0] cfg_wr_data, cfg_rd_data_q;
	logic cfg_rd_valid_q, vpp_otp_pin, two_wire_enable_pin, mstart;
	logic [pwd_pkg::NUM_SRC-1:0][23:0] meas_results;
	logic [pwd_pkg::NUM_PORTS-1:0] gp_out_q, gp_oe_q;
	logic [15:0] win0, win1, high0, high1, rise0, rise1;
	int n_fail, n_checks;

	pwd_top dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.cfg_wr_en(cfg_wr_en), .cfg_wr_addr(cfg_wr_addr),
		.cfg_wr_data(cfg_wr_data), .cfg_rd_en(cfg_rd_en),
		.cfg_rd_addr(cfg_rd_addr), .cfg_rd_data_q(cfg_rd_data_q),
		.cfg_rd_valid_q(cfg_rd_valid_q), .meas_valid(meas_valid),
		.meas_results(meas_results), .vpp_otp_pin(vpp_otp_pin),
		.two_wire_enable_pin(two_wire_enable_pin), .gp_out_q(gp_out_q),
		.gp_oe_q(gp_oe_q));
	pwd_filter_model filt0 (.core_clk(core_clk), .pin_out(gp_out_q[0]),
		.pin_oe(gp_oe_q[0]), .start(mstart), .win(win0),
		.high_cnt(high0), .rise_cnt(rise0));
	pwd_filter_model filt1 (.core_clk(core_clk), .pin_out(gp_out_q[1]),
		.pin_oe(gp_oe_q[1]), .start(mstart), .win(win1),
		.high_cnt(high1), .rise_cnt(rise1));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	function automatic logic [23:0] mkcfg(input logic [3:0] dir,
		input logic [1:0] c0, c1, r0, r1);
		logic [23:0] w;
		w = 24'h000000;
		w[pwd_pkg::DIR_LSB +: 4] = dir;
		w[pwd_pkg::EN_LSB +: 2] = 2'h3;
		w[pwd_pkg::CH0_CARRIER_LSB +: 2] = c0;
		w[pwd_pkg::CH1_CARRIER_LSB +: 2] = c1;
		w[pwd_pkg::CH0_RES_LSB +: 2] = r0;
		w[pwd_pkg::CH1_RES_LSB +: 2] = r1;
		w[pwd_pkg::CH1_DENSITY_BIT] = 1'b1;
		return w;
	endfunction : mkcfg

	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(posedge core_clk);
		cfg_wr_en <= 1'b1;
		cfg_wr_addr <= a;
		cfg_wr_data <= d;
		@(posedge core_clk);
		cfg_wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic ev);
		logic v;
		@(posedge core_clk);
		cfg_rd_en <= 1'b1;
		cfg_rd_addr <= a;
		@(posedge core_clk);
		cfg_rd_en <= 1'b0;
		#1 v = cfg_rd_valid_q;
		`CHK(cfg_rd_data_q, 24'h000000, "read data")
		@(posedge core_clk);
		#1 v = v | cfg_rd_valid_q;
		`CHK(v, ev, "read valid")
	endtask : rd

	task automatic meas(input logic [23:0] r0, r1);
		@(posedge core_clk);
		meas_results[3] <= r0;
		meas_results[5] <= r1;
		meas_valid <= 1'b1;
		@(posedge core_clk);
		meas_valid <= 1'b0;
	endtask : meas

	// Ticks per carrier period are given times four: 25 is 8 MHz.
	task automatic duty(input int v0, v1, t0, t1, n0, n1);
		int p0, p1, pm, e0, e1;
		logic ok;
		p0 = (1 << n0) * t0 / 4;
		p1 = (1 << n1) * t1 / 4;
		pm = (p0 > p1) ? p0 : p1;
		e0 = v0 * t0 / 4;
		e1 = v1 * t1 / 4;
		repeat (2 * pm + 10) @(posedge core_clk);
		win0 <= 16'(p0);
		win1 <= 16'(p1);
		mstart <= 1'b1;
		@(posedge core_clk);
		mstart <= 1'b0;
		repeat (pm + 4) @(posedge core_clk);
		ok = (high0 + v0 / 4 + 4 >= e0) && (high0 <= e0 + v0 / 4 + 4);
		`CHK(ok, 1'b1, "ch0 high time")
		ok = (high1 + v1 / 4 + 4 >= e1) && (high1 <= e1 + v1 / 4 + 4);
		`CHK(ok, 1'b1, "ch1 high time")
		`CHK(rise0, 16'(v0 != 0), "ch0 width runs")
		ok = (rise1 + 1 >= v1) && (rise1 <= v1);
		`CHK(ok, 1'b1, "ch1 density runs")
	endtask : duty

	task automatic s_regs;
		wr(pwd_pkg::ADDR_GPIO_PULSE_CFG, 24'hFFF00F);
		rd(pwd_pkg::ADDR_GPIO_PULSE_CFG, 1'b1);
		rd(pwd_pkg::ADDR_HW_FIRST, 1'b1);
		rd(pwd_pkg::ADDR_HW_LAST, 1'b1);
		rd(pwd_pkg::ADDR_PARAM_LAST, 1'b1);
		rd(6'h14, 1'b0);
	endtask : s_regs

	task automatic s_ports;
		wr(pwd_pkg::ADDR_GPIO_PULSE_CFG, mkcfg(4'h0, 2'h0, 2'h0, 2'h0, 2'h0));
		repeat (6) @(posedge core_clk);
		`CHK(gp_oe_q, 4'hC, "ports held by serial")
		vpp_otp_pin <= 1'b0;
		two_wire_enable_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		`CHK(gp_oe_q, 4'hF, "ports freed")
		clk_en <= 1'b0;
		wr(pwd_pkg::ADDR_GPIO_PULSE_CFG, mkcfg(4'h5, 2'h0, 2'h0, 2'h0, 2'h0));
		clk_en <= 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK(gp_oe_q, 4'hF, "frozen write")
		wr(pwd_pkg::ADDR_GPIO_PULSE_CFG, mkcfg(4'h5, 2'h0, 2'h0, 2'h0, 2'h0));
		repeat (4) @(posedge core_clk);
		`CHK(gp_oe_q, 4'hA, "direction inputs")
		`CHK(gp_out_q & ~gp_oe_q, 4'h0, "undriven level")
		wr(pwd_pkg::ADDR_GPIO_PULSE_CFG, mkcfg(4'h0, 2'h0, 2'h0, 2'h0, 2'h0));
	endtask : s_ports

	// Channel 0 reads source 3 with gain 1, channel 1 source 5 with gain 1/2.
	task automatic s_map;
		wr(pwd_pkg::ADDR_SOURCE_SEL, 24'h000053);
		wr(pwd_pkg::ADDR_CH0_GAIN, 24'h010000);
		wr(pwd_pkg::ADDR_CH0_BIAS, 24'h000000);
		wr(pwd_pkg::ADDR_CH1_GAIN, 24'h008000);
		wr(pwd_pkg::ADDR_CH1_BIAS, 24'h00000A);
		meas(24'h000064, 24'h000050);
		duty(100, 50, 25, 25, 7, 7);
		meas(24'h00007F, 24'h000000);
		duty(127, 10, 25, 25, 7, 7);
		meas(24'h000000, 24'h000000);
		duty(0, 10, 25, 25, 7, 7);
	endtask : s_map

	task automatic s_range;
		meas(24'h000080, 24'h000190);
		duty(0, 10, 25, 25, 7, 7);
		wr(pwd_pkg::ADDR_CH0_BIAS, 24'hFFFF00);
		meas(24'h000080, 24'h000000);
		duty(0, 10, 25, 25, 7, 7);
		meas(24'h00012C, 24'h000000);
		duty(44, 10, 25, 25, 7, 7);
	endtask : s_range

	// Channel 0 at ten bits on 8 MHz, channel 1 at seven bits on 1 MHz.
	task automatic s_res;
		wr(pwd_pkg::ADDR_GPIO_PULSE_CFG, mkcfg(4'h0, 2'h0, 2'h1, 2'h3, 2'h0));
		wr(pwd_pkg::ADDR_CH0_GAIN, 24'hFF0000);
		wr(pwd_pkg::ADDR_CH0_BIAS, 24'h00044C);
		meas(24'h00004D, 24'h000050);
		duty(1023, 50, 25, 200, 10, 7);
	endtask : s_res

	// Channel 1 on the recommended 100 kHz carrier, still 50 of 128 dense.
	task automatic s_slow;
		logic ok;
		wr(pwd_pkg::ADDR_GPIO_PULSE_CFG, mkcfg(4'h0, 2'h0, 2'h2, 2'h3, 2'h0));
		repeat (600) @(posedge core_clk);
		win1 <= 16'h1F40;
		mstart <= 1'b1;
		@(posedge core_clk);
		mstart <= 1'b0;
		repeat (8004) @(posedge core_clk);
		ok = (high1 >= 16'h0960) && (high1 <= 16'h0FA0);
		`CHK(ok, 1'b1, "slow carrier high time")
		ok = (rise1 >= 16'h0005) && (rise1 <= 16'h0008);
		`CHK(ok, 1'b1, "slow carrier runs")
	endtask : s_slow

	task automatic end_of_test;
		if (n_fail == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		n_fail = 0;
		n_checks = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		cfg_wr_en = 1'b0;
		cfg_wr_addr = 6'h00;
		cfg_wr_data = 24'h000000;
		cfg_rd_en = 1'b0;
		cfg_rd_addr = 6'h00;
		meas_valid = 1'b0;
		meas_results = '0;
		vpp_otp_pin = 1'b1;
		two_wire_enable_pin = 1'b0;
		mstart = 1'b0;
		win0 = 16'h0000;
		win1 = 16'h0000;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		`CHK(gp_oe_q, 4'h0, "oe after reset")
		`CHK(cfg_rd_valid_q, 1'b0, "valid after reset")
		s_regs();
		s_ports();
		s_map();
		s_range();
		s_res();
		s_slow();
		end_of_test();
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		n_fail++;
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
